// File: design/eer_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides and a flush.
 * Assumes both sides run on the same clock; flush drops all content.
 */
`default_nettype none

module eer_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock, reset and flush
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] PTR_ZERO = '0;
   localparam logic [AW:0] PTR_ONE = {{AW{1'b0}}, 1'b1};

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;

   wire logic empty = (wr_ptr == rd_ptr);
   wire logic full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire logic push = in_valid && !full && !flush;
   wire logic pop = out_ready && !empty && !flush;

   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= PTR_ZERO;
         rd_ptr <= PTR_ZERO;
      end else if (flush) begin
         wr_ptr <= PTR_ZERO;
         rd_ptr <= PTR_ZERO;
      end else begin
         if (push) wr_ptr <= wr_ptr + PTR_ONE;
         if (pop) rd_ptr <= rd_ptr + PTR_ONE;
      end
   end

   // storage needs no reset; nothing reads a slot before it is written
   always_ff @(posedge core_clk) begin
      if (push) mem[wr_ptr[AW-1:0]] <= in_data;
   end

endmodule // eer_fifo

`default_nettype wire

// File: design/eer_pkg.sv
/*
 * Shared constants and carriers of the serial memory read path.
 * Assumes an 8-bit byte address space behind a two-wire bus slave.
 */
`default_nettype none

package eer_pkg;

   // bus framing
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] BIT_CNT_FULL = 4'h8;
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;

   // slave address: type code then select bits; code value is arbitrary
   localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;
   localparam logic [2:0] DEV_SELECT = 3'h0;

   // memory geometry
   localparam int ADDR_W = 8;
   localparam int MEM_BYTES_DEFAULT = 256;
   localparam int MEM_BYTES_SMALL = 128;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 8'h01;

   // prefetch buffer
   localparam int FIFO_DEPTH_DEFAULT = 16;

   // bus engine states
   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_DEV      = 4'h1,
      ST_DEV_ACK  = 4'h2,
      ST_WADR     = 4'h3,
      ST_WADR_ACK = 4'h4,
      ST_WDAT     = 4'h5,
      ST_WDAT_ACK = 4'h6,
      ST_TX       = 4'h7,
      ST_TX_ACK   = 4'h8
   } eer_state_t;

   // read request toward the memory array (data returns one cycle later)
   typedef struct packed {
      logic en;
      logic [ADDR_W-1:0] addr;
   } eer_mem_req_t;

   // bytes handed to the write path
   typedef struct packed {
      logic byte_valid;
      logic [BYTE_BITS-1:0] data;
      logic commit;
   } eer_wr_evt_t;

endpackage

`default_nettype wire

// File: design/eer_read_path.sv
/*
 * Read side of a two-wire serial memory slave: address phase, current,
 * random and sequential reads, with a prefetch FIFO in front of the array.
 * Assumes a memory array answering one cycle after a read request, a
 * write path that reports busy and may set the address, and an SCL slow
 * enough (several core clocks per phase) for the oversampling here.
 */
`default_nettype none

module eer_read_path #(
   parameter int MEM_BYTES = eer_pkg::MEM_BYTES_DEFAULT,
   parameter int FIFO_DEPTH = eer_pkg::FIFO_DEPTH_DEFAULT,
   parameter logic [3:0] DEV_TYPE = eer_pkg::DEV_TYPE_DEFAULT
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // bus pins (open drain data)
   input wire logic scl_pin,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // write path coupling
   input wire logic wr_busy,
   input wire logic addr_set_valid,
   input wire logic [eer_pkg::ADDR_W-1:0] addr_set_value,
   output eer_pkg::eer_wr_evt_t wr_evt,
   output logic [eer_pkg::ADDR_W-1:0] cur_addr,
   // memory array read port
   output eer_pkg::eer_mem_req_t mem_req,
   input wire logic [eer_pkg::BYTE_BITS-1:0] mem_rdata
);
   localparam int AW = eer_pkg::ADDR_W;
   localparam int BW = eer_pkg::BYTE_BITS;
   localparam logic [AW-1:0] LAST_ADDR = AW'(MEM_BYTES - 1);
   localparam bit NO_WRAP = (MEM_BYTES == eer_pkg::MEM_BYTES_SMALL);

   function automatic logic [AW-1:0] addr_inc(input logic [AW-1:0] a);
      // small part keeps counting past its last byte
      if (!NO_WRAP && a == LAST_ADDR) addr_inc = eer_pkg::ADDR_ZERO;
      else addr_inc = a + eer_pkg::ADDR_ONE;
   endfunction

   // pin synchronisers; first stage is read only by the second
   logic scl_m, scl_s, scl_d;
   logic sda_m, sda_s, sda_d;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
      end else begin
         {scl_m, scl_s, scl_d} <= {scl_pin, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
      end
   end

   wire logic scl_rise = scl_s && !scl_d;
   wire logic scl_fall = !scl_s && scl_d;
   wire logic bus_start = scl_s && scl_d && sda_d && !sda_s;
   wire logic bus_stop = scl_s && scl_d && !sda_d && sda_s;

   // bus engine state
   eer_pkg::eer_state_t state, next_state;
   logic [BW-1:0] shreg, next_shreg;
   logic [3:0] bitcnt, next_bitcnt;
   logic drive_low, next_drive_low;
   logic wseen, next_wseen;
   logic mack, next_mack;
   logic pop, load_addr, wbyte, commit;

   // prefetch side
   logic fifo_in_ready, fifo_out_valid;
   logic [BW-1:0] fifo_out_data;
   logic [AW-1:0] fetch_addr;
   logic pend_live;

   wire logic addr_match = (shreg[BW-1:1] == {DEV_TYPE, eer_pkg::DEV_SELECT});
   wire logic flush = load_addr || addr_set_valid;
   wire logic issue = fifo_in_ready && !pend_live && !flush;
   wire logic push = pend_live && !flush;

   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_bitcnt = bitcnt;
      next_drive_low = drive_low;
      next_wseen = wseen;
      next_mack = mack;
      pop = 1'b0;
      load_addr = 1'b0;
      wbyte = 1'b0;
      commit = 1'b0;
      if (bus_start) begin
         // also the repeated START of a random read
         next_state = eer_pkg::ST_DEV;
         next_bitcnt = eer_pkg::BIT_CNT_ZERO;
         next_drive_low = 1'b0;
      end else if (bus_stop) begin
         commit = (state == eer_pkg::ST_WDAT) && wseen;
         next_state = eer_pkg::ST_IDLE;
         next_drive_low = 1'b0;
      end else begin
         case (state)
            eer_pkg::ST_DEV, eer_pkg::ST_WADR, eer_pkg::ST_WDAT: begin
               if (scl_rise) begin
                  next_shreg = {shreg[BW-2:0], sda_s};
                  next_bitcnt = bitcnt + 4'h1;
               end else if (scl_fall && bitcnt == eer_pkg::BIT_CNT_FULL) begin
                  next_bitcnt = eer_pkg::BIT_CNT_ZERO;
                  if (state == eer_pkg::ST_DEV) begin
                     if (addr_match && !wr_busy) begin
                        next_drive_low = 1'b1;
                        next_state = eer_pkg::ST_DEV_ACK;
                     end else begin
                        next_state = eer_pkg::ST_IDLE;
                     end
                  end else if (state == eer_pkg::ST_WADR) begin
                     load_addr = 1'b1;
                     next_drive_low = 1'b1;
                     next_state = eer_pkg::ST_WADR_ACK;
                  end else begin
                     wbyte = 1'b1;
                     next_wseen = 1'b1;
                     next_drive_low = 1'b1;
                     next_state = eer_pkg::ST_WDAT_ACK;
                  end
               end
            end
            eer_pkg::ST_DEV_ACK: begin
               if (scl_fall) begin
                  next_drive_low = 1'b0;
                  if (shreg[0]) begin
                     pop = 1'b1;
                     next_shreg = fifo_out_data;
                     next_drive_low = !fifo_out_data[BW-1];
                     next_state = eer_pkg::ST_TX;
                  end else begin
                     next_wseen = 1'b0;
                     next_state = eer_pkg::ST_WADR;
                  end
               end
            end
            eer_pkg::ST_WADR_ACK, eer_pkg::ST_WDAT_ACK: begin
               if (scl_fall) begin
                  next_drive_low = 1'b0;
                  next_state = eer_pkg::ST_WDAT;
               end
            end
            eer_pkg::ST_TX: begin
               if (scl_rise) begin
                  next_bitcnt = bitcnt + 4'h1;
               end else if (scl_fall) begin
                  if (bitcnt == eer_pkg::BIT_CNT_FULL) begin
                     next_drive_low = 1'b0;
                     next_state = eer_pkg::ST_TX_ACK;
                  end else begin
                     next_shreg = {shreg[BW-2:0], 1'b0};
                     next_drive_low = !shreg[BW-2];
                  end
               end
            end
            eer_pkg::ST_TX_ACK: begin
               if (scl_rise) begin
                  next_mack = !sda_s;
               end else if (scl_fall) begin
                  next_bitcnt = eer_pkg::BIT_CNT_ZERO;
                  if (mack) begin
                     pop = 1'b1;
                     next_shreg = fifo_out_data;
                     next_drive_low = !fifo_out_data[BW-1];
                     next_state = eer_pkg::ST_TX;
                  end else begin
                     // no-ack: stay off the bus until STOP or START
                     next_state = eer_pkg::ST_IDLE;
                  end
               end
            end
            eer_pkg::ST_IDLE: begin
               next_drive_low = 1'b0;
            end
            default: begin
               next_state = eer_pkg::ST_IDLE;
               next_drive_low = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= eer_pkg::ST_IDLE;
         shreg <= '0;
         bitcnt <= eer_pkg::BIT_CNT_ZERO;
         drive_low <= 1'b0;
         wseen <= 1'b0;
         mack <= 1'b0;
      end else begin
         state <= next_state;
         shreg <= next_shreg;
         bitcnt <= next_bitcnt;
         drive_low <= next_drive_low;
         wseen <= next_wseen;
         mack <= next_mack;
      end
   end

   // address register shared with the write path; its set wins
   wire logic [AW-1:0] next_cur_addr = addr_set_valid ? addr_set_value :
                                      load_addr ? shreg :
                                      (pop && fifo_out_valid) ? addr_inc(cur_addr) : cur_addr;
   // refetch restarts wherever the address was moved to
   wire logic [AW-1:0] next_fetch_addr = addr_set_valid ? addr_set_value :
                                        load_addr ? shreg :
                                        issue ? addr_inc(fetch_addr) : fetch_addr;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur_addr <= eer_pkg::ADDR_RESET;
         fetch_addr <= eer_pkg::ADDR_RESET;
         pend_live <= 1'b0;
         mem_req <= '0;
         wr_evt <= '0;
      end else begin
         cur_addr <= next_cur_addr;
         fetch_addr <= next_fetch_addr;
         pend_live <= issue;
         mem_req <= '{en: issue, addr: fetch_addr};
         wr_evt <= '{byte_valid: wbyte, data: shreg, commit: commit};
      end
   end

   // request leaves a cycle late, so the read data meet pend_live
   eer_fifo #(
      .WIDTH(BW),
      .DEPTH(FIFO_DEPTH)
   ) u_prefetch (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .flush(flush),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(mem_rdata),
      .out_valid(fifo_out_valid),
      .out_ready(pop),
      .out_data(fifo_out_data)
   );

   assign sda_out = 1'b0;
   assign sda_oe_n = !drive_low;

endmodule // eer_read_path

`default_nettype wire

// File: testbench/eer_bus_master.sv
/* two-wire bus master model: start, stop, byte out and byte in.
   assumes a pulled-up sda resolved by the bench; steps on core_clk falls. */
`default_nettype none
module eer_bus_master (
   // timing reference
   input wire logic core_clk,
   // bus
   output logic scl,
   output logic sda_rel,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic q(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // 160 ns bit: low 5 clocks, high 3; scl stands high between frames
   task automatic bitx(input logic b, output logic r);
      q(2);
      sda_rel = b;
      q(3);
      scl = 1'b1;
      q(2);
      r = sda;
      q(1);
      scl = 1'b0;
   endtask
   // long low wait lets the slave drop its ack before a repeated start
   task automatic start();
      sda_rel = 1'b1;
      q(5);
      scl = 1'b1;
      q(3);
      sda_rel = 1'b0;
      q(3);
      scl = 1'b0;
   endtask
   task automatic stop();
      q(2);
      sda_rel = 1'b0;
      q(3);
      scl = 1'b1;
      q(3);
      sda_rel = 1'b1;
      q(4);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(~ack, r);
   endtask
endmodule // eer_bus_master
`default_nettype wire

// File: testbench/eer_read_path_props.sv
/* checker of the read path: bus timing, ack, address load, write events.
   assumes binding to eer_read_path and scl phases of 3 or more clocks. */
`default_nettype none
module eer_read_path_props (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // bus
   input wire logic scl_pin,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   // write path and memory
   input wire logic wr_busy,
   input wire logic addr_set_valid,
   input wire logic [eer_pkg::ADDR_W-1:0] addr_set_value,
   input wire eer_pkg::eer_wr_evt_t wr_evt,
   input wire logic [eer_pkg::ADDR_W-1:0] cur_addr,
   input wire eer_pkg::eer_mem_req_t mem_req,
   input wire logic [eer_pkg::BYTE_BITS-1:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_seen;
   always_ff @(posedge core_clk or negedge arst_n)
      if (!arst_n) wr_seen <= 1'b0;
      else wr_seen <= (wr_seen | wr_evt.byte_valid) & ~wr_evt.commit;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence s_stop;
      scl_pin && $past(scl_pin) && $rose(sda_in);
   endsequence
   property p_od; sda_out == 1'b0; endproperty
   property p_drv_low; $fell(sda_oe_n) |-> !scl_pin; endproperty
   property p_hold; $rose(scl_pin) |=> $stable(sda_oe_n) [*2]; endproperty
   property p_stand; $fell(sda_oe_n) |=> !sda_oe_n [*4]; endproperty
   property p_busy; wr_busy && $past(wr_busy) |-> !$fell(sda_oe_n); endproperty
   property p_stop; s_stop |-> ##[0:6] sda_oe_n; endproperty
   property p_load; addr_set_valid |=> cur_addr == $past(addr_set_value); endproperty
   property p_commit; wr_evt.commit |-> wr_seen || wr_evt.byte_valid; endproperty
   a_od: assert property (p_od)
      else $error("sda_out not low");
   a_drv_low: assert property (p_drv_low)
      else $error("drive began with scl high");
   a_hold: assert property (p_hold)
      else $error("sda moved with scl high");
   a_stand: assert property (p_stand)
      else $error("driven bit too short");
   a_busy: assert property (p_busy)
      else $error("drive while write busy");
   a_stop: assert property (p_stop)
      else $error("sda held after stop");
   a_load: assert property (p_load)
      else $error("address not loaded");
   a_commit: assert property (p_commit)
      else $error("commit without data byte");
endmodule // eer_read_path_props
bind eer_read_path eer_read_path_props eer_read_path_props_inst (
   .core_clk(core_clk), .arst_n(arst_n), .scl_pin(scl_pin), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wr_busy(wr_busy),
   .addr_set_valid(addr_set_valid), .addr_set_value(addr_set_value),
   .wr_evt(wr_evt), .cur_addr(cur_addr), .mem_req(mem_req), .mem_rdata(mem_rdata)
);
`default_nettype wire

// File: testbench/testbench.sv
/* self-checking bench of the read path: random, sequential, current, refused,
   aborted, write-direction and small-array sessions. assumes a one-cycle array model. */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] dev_w = {eer_pkg::DEV_TYPE_DEFAULT, eer_pkg::DEV_SELECT, 1'b0};
   localparam logic [7:0] dev_r = dev_w | 8'h01;
   logic core_clk = 1'b0, arst_n = 1'b0, wr_busy = 1'b0, addr_set_valid = 1'b0;
   logic scl, sda_rel, sda_out, sda_oe_n;
   logic [7:0] addr_set_value = 8'h00, mem_rdata = 8'h00, cur_addr, wdat;
   eer_pkg::eer_wr_evt_t wr_evt;
   eer_pkg::eer_mem_req_t mem_req;
   // second slave on the same bus: small array variant, type code is arbitrary
   localparam logic [3:0] small_type = 4'h6;
   localparam logic [7:0] small_r = {small_type, eer_pkg::DEV_SELECT, 1'b1};
   logic sda_out_s, sda_oe_n_s;
   logic [7:0] mem_rdata_s = 8'h00, cur_addr_s;
   eer_pkg::eer_mem_req_t mem_req_s;
   int n_errors = 0, n_compared = 0, cyc = 0, n_commit = 0;
   wire logic sda = sda_rel & (sda_oe_n | sda_out) & (sda_oe_n_s | sda_out_s);
   eer_read_path eer_read_path_inst (
      .core_clk(core_clk), .arst_n(arst_n), .scl_pin(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wr_busy(wr_busy),
      .addr_set_valid(addr_set_valid), .addr_set_value(addr_set_value),
      .wr_evt(wr_evt), .cur_addr(cur_addr), .mem_req(mem_req), .mem_rdata(mem_rdata)
   );
   eer_read_path #(
      .MEM_BYTES(eer_pkg::MEM_BYTES_SMALL),
      .DEV_TYPE(small_type)
   ) eer_read_path_small_inst (
      .core_clk(core_clk), .arst_n(arst_n), .scl_pin(scl), .sda_in(sda),
      .sda_out(sda_out_s), .sda_oe_n(sda_oe_n_s), .wr_busy(wr_busy),
      .addr_set_valid(addr_set_valid), .addr_set_value(addr_set_value),
      .wr_evt(), .cur_addr(cur_addr_s), .mem_req(mem_req_s), .mem_rdata(mem_rdata_s)
   );
   eer_bus_master eer_bus_master_inst (
      .core_clk(core_clk), .scl(scl), .sda_rel(sda_rel), .sda(sda)
   );
   always #10 core_clk = ~core_clk;
   function automatic logic [7:0] f(input logic [7:0] a);
      return a ^ 8'ha5;
   endfunction
   always @(negedge core_clk) if (mem_req.en) mem_rdata <= f(mem_req.addr);
   always @(negedge core_clk) if (mem_req_s.en) mem_rdata_s <= f(mem_req_s.addr);
   always @(posedge core_clk) begin
      if (wr_evt.byte_valid) wdat <= wr_evt.data;
      if (wr_evt.commit) n_commit++;
      cyc++;
      if (cyc == 10000) begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic st(); eer_bus_master_inst.start(); endtask
   task automatic sp(); eer_bus_master_inst.stop(); endtask
   task automatic wb(input logic [7:0] d, input logic a);
      logic r;
      eer_bus_master_inst.wbyte(d, r);
      cmp("ack", {7'h0, a}, {7'h0, r});
   endtask
   task automatic rb(input logic a, input logic [7:0] e);
      logic [7:0] d;
      eer_bus_master_inst.rbyte(a, d);
      cmp("data", e, d);
   endtask
   task automatic t_random();
      st();
      wb(dev_w, 1'b1);
      wb(8'hfe, 1'b1);
      st();
      wb(dev_r, 1'b1);
      rb(1'b1, f(8'hfe));
      rb(1'b1, f(8'hff));
      rb(1'b1, f(8'h00));
      rb(1'b0, f(8'h01));
      sp();
      cmp("commits", 8'h00, n_commit[7:0]);
      cmp("addr", 8'h02, cur_addr);
      $display("random and sequential read done");
   endtask
   task automatic t_current();
      st();
      wb(dev_r, 1'b1);
      rb(1'b0, f(8'h02));
      sp();
      cmp("sda idle", 8'h01, {7'h0, sda_oe_n});
      $display("current read done");
   endtask
   task automatic t_refuse();
      st();
      wb({eer_pkg::DEV_TYPE_DEFAULT, 3'h1, 1'b1}, 1'b0);
      sp();
      st();
      wb({eer_pkg::DEV_TYPE_DEFAULT ^ 4'h1, 3'h0, 1'b1}, 1'b0);
      sp();
      wr_busy = 1'b1;
      st();
      wb(dev_r, 1'b0);
      sp();
      wr_busy = 1'b0;
      $display("refused addresses done");
   endtask
   task automatic t_write();
      st();
      wb(dev_w, 1'b1);
      wb(8'h30, 1'b1);
      wb(8'h77, 1'b1);
      sp();
      cmp("write data", 8'h77, wdat);
      cmp("commits", 8'h01, n_commit[7:0]);
      addr_set_value = 8'h40;
      addr_set_valid = 1'b1;
      @(negedge core_clk);
      addr_set_valid = 1'b0;
      st();
      wb(dev_r, 1'b1);
      rb(1'b0, f(8'h40));
      sp();
      $display("write and address load done");
   endtask
   task automatic t_abort();
      logic r;
      st();
      repeat (3) eer_bus_master_inst.bitx(1'b0, r);
      st();
      wb(dev_r, 1'b1);
      rb(1'b0, f(8'h03));
      sp();
      $display("aborted address done");
   endtask
   task automatic t_small();
      addr_set_value = 8'h7f;
      addr_set_valid = 1'b1;
      @(negedge core_clk);
      addr_set_valid = 1'b0;
      st();
      wb(small_r, 1'b1);
      rb(1'b1, f(8'h7f));
      rb(1'b0, f(8'h80));
      sp();
      cmp("small addr", 8'h81, cur_addr_s);
      $display("small array read done");
   endtask
   initial begin
      repeat (2) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (6) @(negedge core_clk);
      t_random();
      t_current();
      t_refuse();
      t_abort();
      t_write();
      t_small();
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
